// file: verilog/mpwp_defines.svh
`ifndef MPWP_DEFINES_SVH
`define MPWP_DEFINES_SVH
// =====================================================
// Register byte offsets
`define MPWP_OFS_KEY 8'h00
`define MPWP_OFS_EMG_CTRL 8'h04
`define MPWP_OFS_EMG_STAT 8'h08
`define MPWP_OFS_OVV_CTRL 8'h0c
`define MPWP_OFS_OVV_STAT 8'h10
// =====================================================
// Field positions
`define MPWP_CTRL_EN 0
`define MPWP_CTRL_RS 1
`define MPWP_CTRL_MD_LO 3
`define MPWP_CTRL_MD_HI 4
`define MPWP_CTRL_HALT 5
`define MPWP_CTRL_CNT_LO 8
`define MPWP_CTRL_CNT_HI 11
`define MPWP_STAT_ST 0
`define MPWP_STAT_LVL 1
// =====================================================
// Reset values and codes
`define MPWP_RST_EMG_EN 1'b1
`define MPWP_RST_HALT 1'b1
`define MPWP_RST_EMG_MD 2'h3
`define MPWP_RST_OVV_MD 2'h0
`define MPWP_KEY_FIRST 8'h5a
`define MPWP_KEY_SECOND 8'ha5
`define MPWP_FILT_SHIFT 4
`define MPWP_RESP_OKAY 2'h0
`define MPWP_RESP_SLVERR 2'h2
`endif

// file: verilog/mpwp_pkg.sv
package mpwp_pkg;
   typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_ARMED} mpwp_key_t;

   // Forced phase mode plus port high-Z requests
   typedef struct packed {
      logic [1:0] mode;
      logic hiz_upper;
      logic hiz_lower;
   } mpwp_drive_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_full;
      logic w_full;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] emg_sync;
      logic [1:0] ovv_sync;
      logic [1:0] brk_sync;
      logic emg_filt;
      logic ovv_filt;
      logic [7:0] emg_cnt;
      logic [7:0] ovv_cnt;
      mpwp_key_t key;
      logic [3:0] emg_time;
      logic halt_en;
      logic [1:0] emg_mode;
      logic emg_en;
      logic [3:0] ovv_time;
      logic [1:0] ovv_mode;
      logic ovv_auto;
      logic ovv_en;
      logic emg_state;
      logic ovv_state;
      logic emg_irq;
      logic ovv_irq;
      logic pwm_stop;
      mpwp_drive_t drive;
   } mpwp_state_t;
endpackage

// file: verilog/mpwp_protect.sv
`timescale 1ns/10ps
`include "mpwp_defines.svh"

module mpwp_protect
   import mpwp_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Pins; detect lines active low, tool stop active high
   input wire logic emergency_stop_input,
   input wire logic overvoltage_input,
   input wire logic tool_stop,
   // PWM unit side
   input wire logic [15:0] pwm_counter,
   input wire logic [15:0] pwm_period_value,
   input wire logic half_period_mode,
   input wire logic output_ctrl_idle,
   // Protection outputs
   output mpwp_drive_t phase_drive,
   output logic pwm_stop,
   output logic emergency_irq,
   output logic overvoltage_irq,
   output logic emergency_protect_state,
   output logic overvoltage_protect_state
);

   mpwp_state_t s;
   mpwp_state_t next_s;

   // =====================================================
   // Helpers
   // Returns {level, count}; mismatch must persist for limit clocks
   function automatic logic [8:0] filt_step(logic lvl, logic raw,
         logic [7:0] cnt, logic [3:0] tim, logic bypass);
      logic [7:0] limit;
      limit = {tim, 4'h0};
      if (bypass) begin
         filt_step = {raw, 8'h00};
      end else if (raw == lvl) begin
         filt_step = {lvl, 8'h00};
      end else if (cnt + 8'h01 >= limit) begin
         filt_step = {raw, 8'h00};
      end else begin
         filt_step = {lvl, cnt + 8'h01};
      end
   endfunction

   function automatic logic [31:0] ctrl_word(logic [3:0] tim,
         logic [1:0] md, logic rs_auto, logic en, logic halt);
      ctrl_word = 32'h0;
      ctrl_word[`MPWP_CTRL_CNT_HI:`MPWP_CTRL_CNT_LO] = tim;
      ctrl_word[`MPWP_CTRL_MD_HI:`MPWP_CTRL_MD_LO] = md;
      ctrl_word[`MPWP_CTRL_HALT] = halt;
      ctrl_word[`MPWP_CTRL_RS] = rs_auto;
      ctrl_word[`MPWP_CTRL_EN] = en;
   endfunction

   function automatic logic [31:0] stat_word(logic lvl, logic st);
      stat_word = 32'h0;
      stat_word[`MPWP_STAT_LVL] = lvl;
      stat_word[`MPWP_STAT_ST] = st;
   endfunction

   // =====================================================
   // Next state
   always_comb begin
      logic wr_go;
      logic [31:0] d;
      logic emg_fall;
      logic ovv_fall;
      logic emg_release;
      logic period_point;
      wr_go = 1'b0;
      d = 32'h0;
      emg_fall = 1'b0;
      ovv_fall = 1'b0;
      emg_release = 1'b0;
      period_point = 1'b0;
      next_s = s;
      next_s.emg_irq = 1'b0;
      next_s.ovv_irq = 1'b0;

      // Bus capture; address and data may arrive in either order
      if (awvalid && s.awready) begin
         next_s.aw_full = 1'b1;
         next_s.waddr = awaddr;
      end
      if (wvalid && s.wready) begin
         next_s.w_full = 1'b1;
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      wr_go = s.aw_full && s.w_full && !s.bvalid;
      d = s.wdata;

      // Synchronisers, first stage read only by the second
      next_s.emg_sync = {s.emg_sync[0], emergency_stop_input};
      next_s.ovv_sync = {s.ovv_sync[0], overvoltage_input};
      next_s.brk_sync = {s.brk_sync[0], tool_stop};

      {next_s.emg_filt, next_s.emg_cnt} = filt_step(s.emg_filt,
         s.emg_sync[1], s.emg_cnt, s.emg_time,
         s.emg_time == 4'h0);
      // Overvoltage count of zero behaves as one
      {next_s.ovv_filt, next_s.ovv_cnt} = filt_step(s.ovv_filt,
         s.ovv_sync[1], s.ovv_cnt,
         (s.ovv_time == 4'h0) ? 4'h1 : s.ovv_time, 1'b0);
      emg_fall = s.emg_filt && !next_s.emg_filt;
      ovv_fall = s.ovv_filt && !next_s.ovv_filt;

      // Register writes
      if (wr_go) begin
         next_s.aw_full = 1'b0;
         next_s.w_full = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = `MPWP_RESP_OKAY;
         next_s.key = KEY_IDLE;
         unique case (s.waddr)
            `MPWP_OFS_KEY: begin
               if (s.wstrb[0] && d[7:0] == `MPWP_KEY_FIRST) begin
                  next_s.key = KEY_ONE;
               end else if (s.wstrb[0] && s.key == KEY_ONE &&
                     d[7:0] == `MPWP_KEY_SECOND) begin
                  next_s.key = KEY_ARMED;
               end
            end
            `MPWP_OFS_EMG_CTRL: begin
               if (s.wstrb[1]) begin
                  next_s.emg_time =
                     d[`MPWP_CTRL_CNT_HI:`MPWP_CTRL_CNT_LO];
               end
               if (s.wstrb[0]) begin
                  next_s.halt_en = d[`MPWP_CTRL_HALT];
                  next_s.emg_mode =
                     d[`MPWP_CTRL_MD_HI:`MPWP_CTRL_MD_LO];
                  // Release needs outputs idle and input high
                  emg_release = d[`MPWP_CTRL_RS] && output_ctrl_idle &&
                     s.emg_sync[1];
                  if (d[`MPWP_CTRL_EN]) begin
                     next_s.emg_en = 1'b1;
                  end else if (s.key == KEY_ARMED) begin
                     next_s.emg_en = 1'b0;
                  end
               end
            end
            `MPWP_OFS_OVV_CTRL: begin
               if (s.wstrb[1]) begin
                  next_s.ovv_time =
                     d[`MPWP_CTRL_CNT_HI:`MPWP_CTRL_CNT_LO];
               end
               if (s.wstrb[0]) begin
                  next_s.ovv_mode =
                     d[`MPWP_CTRL_MD_HI:`MPWP_CTRL_MD_LO];
                  next_s.ovv_auto = d[`MPWP_CTRL_RS];
                  if (d[`MPWP_CTRL_EN]) begin
                     next_s.ovv_en = 1'b1;
                  end else if (s.key == KEY_ARMED) begin
                     next_s.ovv_en = 1'b0;
                  end
               end
            end
            `MPWP_OFS_EMG_STAT, `MPWP_OFS_OVV_STAT: begin
            end
            default: begin
               next_s.bresp = `MPWP_RESP_SLVERR;
            end
         endcase
      end
      next_s.awready = !next_s.aw_full && !next_s.bvalid;
      next_s.wready = !next_s.w_full && !next_s.bvalid;

      // Reads answered one cycle after the address is taken
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = `MPWP_RESP_OKAY;
         unique case (araddr)
            `MPWP_OFS_KEY: next_s.rdata = 32'h0;
            `MPWP_OFS_EMG_CTRL: next_s.rdata = ctrl_word(s.emg_time,
               s.emg_mode, 1'b0, s.emg_en, s.halt_en);
            `MPWP_OFS_EMG_STAT: next_s.rdata = stat_word(s.emg_sync[1],
               s.emg_state);
            `MPWP_OFS_OVV_CTRL: next_s.rdata = ctrl_word(s.ovv_time,
               s.ovv_mode, s.ovv_auto, s.ovv_en, 1'b0);
            `MPWP_OFS_OVV_STAT: next_s.rdata = stat_word(s.ovv_sync[1],
               s.ovv_state);
            default: begin
               next_s.rdata = 32'h0;
               next_s.rresp = `MPWP_RESP_SLVERR;
            end
         endcase
      end
      next_s.arready = !next_s.rvalid;

      // Emergency path; a new fall beats a same-cycle release
      if (!next_s.emg_en || emg_release) begin
         next_s.emg_state = 1'b0;
      end
      if (s.emg_en && emg_fall) begin
         next_s.emg_state = 1'b1;
         next_s.emg_irq = 1'b1;
      end

      // Overvoltage path
      period_point = (pwm_counter == pwm_period_value) ||
         (half_period_mode && pwm_counter == 16'h0001);
      if (!next_s.ovv_en) begin
         next_s.ovv_state = 1'b0;
      end else if (s.ovv_auto && s.ovv_filt && period_point) begin
         next_s.ovv_state = 1'b0;
      end
      if (s.ovv_en && ovv_fall) begin
         next_s.ovv_state = 1'b1;
         next_s.ovv_irq = 1'b1;
      end

      next_s.pwm_stop = s.brk_sync[1] && s.halt_en;

      // Emergency mode has priority over overvoltage mode
      next_s.drive = '0;
      if (next_s.emg_state) begin
         next_s.drive.mode = next_s.emg_mode;
         next_s.drive.hiz_upper = next_s.emg_mode != 2'h1;
         next_s.drive.hiz_lower = next_s.emg_mode != 2'h2;
      end else if (next_s.ovv_state) begin
         next_s.drive.mode = next_s.ovv_mode;
      end
   end

   // =====================================================
   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.emg_sync <= 2'h3;
         s.ovv_sync <= 2'h3;
         s.emg_filt <= 1'b1;
         s.ovv_filt <= 1'b1;
         s.key <= KEY_IDLE;
         s.halt_en <= `MPWP_RST_HALT;
         s.emg_mode <= `MPWP_RST_EMG_MD;
         s.emg_en <= `MPWP_RST_EMG_EN;
         s.ovv_mode <= `MPWP_RST_OVV_MD;
      end else begin
         s <= next_s;
      end
   end

   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign phase_drive = s.drive;
   assign pwm_stop = s.pwm_stop;
   assign emergency_irq = s.emg_irq;
   assign overvoltage_irq = s.ovv_irq;
   assign emergency_protect_state = s.emg_state;
   assign overvoltage_protect_state = s.ovv_state;

   // =====================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_emg_fall;
      s.emg_en && s.emg_filt && !next_s.emg_filt;
   endsequence

   sequence s_key_read;
      arvalid && arready && araddr == `MPWP_OFS_KEY;
   endsequence

   a_key_reads_zero: assert property (
      s_key_read |=> rvalid && rdata == 32'h0)
      else $error("key register read not zero");

   a_emg_entry_irq: assert property (
      s_emg_fall |=> emergency_protect_state && emergency_irq
         ##1 !emergency_irq)
      else $error("emergency entry or irq pulse wrong");

   a_emg_low_hold: assert property (
      emergency_protect_state && !s.emg_sync[1] && next_s.emg_en
         |=> emergency_protect_state)
      else $error("emergency released while input low");

   a_emg_en_locked: assert property (
      s.emg_en && s.key != KEY_ARMED |=> s.emg_en)
      else $error("emergency enable cleared without key");

   a_ovv_en_locked: assert property (
      s.ovv_en && s.key != KEY_ARMED |=> s.ovv_en)
      else $error("overvoltage enable cleared without key");

   a_emg_mode_wins: assert property (
      emergency_protect_state |-> phase_drive.mode == s.emg_mode)
      else $error("emergency mode not applied");

   a_ovv_drive_mode: assert property (
      !emergency_protect_state && overvoltage_protect_state
         |-> phase_drive.mode == s.ovv_mode && !phase_drive.hiz_upper)
      else $error("overvoltage mode not applied");

   a_ovv_low_hold: assert property (
      overvoltage_protect_state && !s.ovv_filt && next_s.ovv_en
         |=> overvoltage_protect_state)
      else $error("overvoltage released while input low");

   a_ovv_auto_rel: assert property (
      overvoltage_protect_state && s.ovv_auto && s.ovv_filt &&
         s.ovv_sync[1] && pwm_counter == pwm_period_value
         |=> !overvoltage_protect_state)
      else $error("overvoltage auto release missed");

   a_halt_stop: assert property (
      s.brk_sync[1] && s.halt_en |=> pwm_stop)
      else $error("tool break did not stop PWM");

   a_emg_bypass: assert property (
      s.emg_time == 4'h0 |=> s.emg_filt == $past(s.emg_sync[1]))
      else $error("filter not bypassed at count zero");

endmodule // mpwp_protect

// file: verif/mpwp_pins_model.sv
`timescale 1ns/10ps
// ==========================
// Far side: detect lines, tool stop, PWM counter
module mpwp_pins_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Commands from the bench
   input wire logic emg_low,
   input wire logic ovv_low,
   input wire logic brk,
   input wire logic [15:0] period,
   // Lines into the block
   output logic emergency_stop_input,
   output logic overvoltage_input,
   output logic tool_stop,
   output logic [15:0] pwm_counter
);
   // Detect lines pulled up, so idle is high
   assign emergency_stop_input = ~emg_low;
   assign overvoltage_input = ~ovv_low;
   assign tool_stop = brk;
   // Runs 1..period so both release points occur
   always_ff @(posedge aclk) begin
      if (!aresetn || pwm_counter >= period) begin
         pwm_counter <= 16'h0001;
      end else begin
         pwm_counter <= pwm_counter + 16'h0001;
      end
   end
endmodule // mpwp_pins_model

// file: verif/test_motor_pwm_emergency_overvoltage_protect.sv
`timescale 1ns/10ps
module test_motor_pwm_emergency_overvoltage_protect;
   import mpwp_pkg::*;
   // ==========================
   // Signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic emg_low = 1'b0, ovv_low = 1'b0, brk = 1'b0;
   logic half = 1'b0, idle = 1'b1;
   logic [15:0] period = 16'h0010, cnt, last;
   logic emg_n, ovv_n, tstop, pwm_stop, e_irq, o_irq, e_st, o_st;
   mpwp_drive_t drv;
   int fails = 0, n_tests = 0, n_eirq = 0, n_oirq = 0;

   always #10 aclk = ~aclk;

   mpwp_protect u_mpwp_protect (.aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .emergency_stop_input(emg_n), .overvoltage_input(ovv_n),
      .tool_stop(tstop), .pwm_counter(cnt), .pwm_period_value(period),
      .half_period_mode(half), .output_ctrl_idle(idle),
      .phase_drive(drv), .pwm_stop(pwm_stop), .emergency_irq(e_irq),
      .overvoltage_irq(o_irq), .emergency_protect_state(e_st),
      .overvoltage_protect_state(o_st));

   mpwp_pins_model u_mpwp_pins_model (.aclk(aclk), .aresetn(aresetn),
      .emg_low(emg_low), .ovv_low(ovv_low), .brk(brk), .period(period),
      .emergency_stop_input(emg_n), .overvoltage_input(ovv_n),
      .tool_stop(tstop), .pwm_counter(cnt));

   // Interrupts are pulses, so count them as they pass
   always @(posedge aclk) begin
      if (e_irq === 1'b1) n_eirq++;
      if (o_irq === 1'b1) n_oirq++;
   end

   // ==========================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] got,
         input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while ((awvalid || wvalid || bvalid !== 1'b1) && n < 100) begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         rs = bresp;
      end
      if (n >= 100) fails++;
      bready <= 1'b0;
   endtask

   task automatic rd32(input logic [7:0] a);
      int n = 0;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while ((arvalid || rvalid !== 1'b1) && n < 100) begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
         rd = rdata;
         rs = rresp;
      end
      if (n >= 100) fails++;
      rready <= 1'b0;
   endtask

   task automatic wait_st(input bit ov, input logic v);
      int n = 0;
      while ((ov ? o_st : e_st) !== v && n < 200) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 200) fails++;
   endtask

   task automatic emg_trip(input logic [1:0] m);
      int k;
      logic [1:0] hz;
      k = n_eirq;
      hz = (m == 2'h1) ? 2'h1 : (m == 2'h2) ? 2'h2 : 2'h3;
      wr(8'h04, 32'h21 | {m, 3'b0});
      emg_low <= 1'b1;
      wait_st(0, 1'b1);
      chk("emg state", e_st, 1'b1);
      chk("drive", drv, {m, hz});
      repeat (3) @(posedge aclk);
      chk("emg irq", n_eirq, k + 1);
   endtask

   task automatic emg_release;
      emg_low <= 1'b0;
      repeat (4) @(posedge aclk);
      rd32(8'h08);
      chk("emg status", rd, 32'h3);
      idle <= 1'b0;
      wr(8'h04, 32'h3b);
      chk("release busy", e_st, 1'b1);
      idle <= 1'b1;
      wr(8'h04, 32'h3b);
      chk("released", e_st, 1'b0);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================
   // Tests
   initial begin
      #1000000;
      fails++;
      tally_and_finish;
   end

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd32(8'h04);
      chk("emg ctrl reset", rd, 32'h39);
      rd32(8'h08);
      chk("emg status reset", rd, 32'h2);
      rd32(8'h00);
      chk("key reads zero", rd, 32'h0);
      rd32(8'h20);
      chk("unmapped read", {rd[29:0], rs}, 32'h2);
      wr(8'h20, 32'h1);
      chk("unmapped write", rs, 2'h2);
      for (int m = 0; m < 4; m++) begin
         emg_trip(m[1:0]);
         if (m == 0) begin
            wr(8'h04, 32'h23);
            chk("release while low", e_st, 1'b1);
         end
         emg_release;
      end
      // Filter: short glitch refused, long low accepted
      wr(8'h04, 32'h139);
      emg_low <= 1'b1;
      repeat (8) @(posedge aclk);
      emg_low <= 1'b0;
      repeat (30) @(posedge aclk);
      chk("glitch filtered", e_st, 1'b0);
      emg_low <= 1'b1;
      repeat (12) @(posedge aclk);
      chk("filter early", e_st, 1'b0);
      wait_st(0, 1'b1);
      chk("filter passed", e_st, 1'b1);
      emg_release;
      // Unlock sequence
      wr(8'h04, 32'h38);
      rd32(8'h04);
      chk("clear without key", rd, 32'h39);
      wr(8'h00, 32'h5a);
      wr(8'h00, 32'h00);
      wr(8'h00, 32'ha5);
      wr(8'h04, 32'h38);
      rd32(8'h04);
      chk("broken key", rd, 32'h39);
      wr(8'h00, 32'h5a);
      wr(8'h00, 32'ha5);
      wr(8'h04, 32'h38);
      rd32(8'h04);
      chk("clear with key", rd, 32'h38);
      emg_low <= 1'b1;
      repeat (30) @(posedge aclk);
      chk("emg disabled", e_st, 1'b0);
      emg_low <= 1'b0;
      repeat (4) @(posedge aclk);
      wr(8'h04, 32'h39);
      // Overvoltage entry and automatic release
      for (int hm = 0; hm < 2; hm++) begin
         // Second pass moves to the lower-on mode
         wr(8'h0c, hm ? 32'h113 : 32'h10b);
         half <= hm[0];
         last = 16'h0;
         ovv_low <= 1'b1;
         wait_st(1, 1'b1);
         chk("ovv mode", drv.mode, hm ? 2'h2 : 2'h1);
         rd32(8'h10);
         chk("ovv status", rd, 32'h1);
         repeat (40) @(posedge aclk);
         chk("ovv held", o_st, 1'b1);
         chk("ovv irq", n_oirq, hm + 1);
         ovv_low <= 1'b0;
         for (int n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (o_st === 1'b0) break;
            last = cnt;
         end
         chk("ovv released", o_st, 1'b0);
         chk("release point", last === period ||
            (hm == 1 && last === 16'h1), 1'b1);
      end
      // Emergency mode wins over overvoltage mode
      ovv_low <= 1'b1;
      wait_st(1, 1'b1);
      emg_trip(2'h3);
      chk("priority", drv.mode, 2'h3);
      emg_release;
      ovv_low <= 1'b0;
      wait_st(1, 1'b0);
      wr(8'h0c, 32'h10a);
      rd32(8'h0c);
      chk("ovv clear no key", rd, 32'h10b);
      wr(8'h00, 32'h5a);
      wr(8'h00, 32'ha5);
      wr(8'h0c, 32'h10a);
      rd32(8'h0c);
      chk("ovv clear key", rd, 32'h10a);
      ovv_low <= 1'b1;
      repeat (40) @(posedge aclk);
      chk("ovv disabled", o_st, 1'b0);
      ovv_low <= 1'b0;
      // Tool stop honoured only while enabled
      brk <= 1'b1;
      repeat (5) @(posedge aclk);
      chk("tool stop", pwm_stop, 1'b1);
      wr(8'h04, 32'h19);
      repeat (3) @(posedge aclk);
      chk("tool stop off", pwm_stop, 1'b0);
      brk <= 1'b0;
      tally_and_finish;
   end
endmodule // test_motor_pwm_emergency_overvoltage_protect
